/* File: rtl/frt_pkg.sv */
// frt_pkg: shared constants and types of the free-running / pulse timer
package frt_pkg;

  // ----------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------
  localparam int unsigned CNT_W   = 16;
  localparam int unsigned ADDR_W  = 3;
  localparam int unsigned DATA_W  = 32;
  localparam int unsigned BE_W    = 4;
  localparam int unsigned CSEL_W  = 2;
  localparam int unsigned DIV_W   = 3;

  // ----------------------------------------------------------------------
  // register word addresses
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_MODE   = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_CAPCMP = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_OUTCTL = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_PRESC  = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_COUNT  = 3'h4;
  localparam logic [ADDR_W-1:0] OFS_REG_A  = 3'h5;
  localparam logic [ADDR_W-1:0] OFS_REG_B  = 3'h6;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int unsigned MODE_OVF_BIT = 0;
  localparam int unsigned MODE_CTE_BIT = 1;
  localparam int unsigned MODE_SEL_LSB = 2;
  localparam int unsigned CC_A_CAP_BIT = 0;
  localparam int unsigned CC_A_SRC_BIT = 1;
  localparam int unsigned CC_B_CAP_BIT = 2;
  localparam int unsigned OC_EN_BIT    = 0;
  localparam int unsigned OC_SRC_LSB   = 2;
  localparam int unsigned OC_LVL_BIT   = 4;
  localparam int unsigned PR_CLK_LSB   = 0;
  localparam int unsigned PR_EA_LSB    = 3;
  localparam int unsigned PR_EB_LSB    = 5;

  // ----------------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0] MODE_STOP = 2'h0;
  localparam logic [1:0] MODE_FREE = 2'h1;
  localparam logic [1:0] MODE_PPG  = 2'h3;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // ----------------------------------------------------------------------
  // reset and counter values
  // ----------------------------------------------------------------------
  localparam logic [CNT_W-1:0]  CNT_ZERO  = 16'h0000;
  localparam logic [CNT_W-1:0]  CNT_ONE   = 16'h0001;
  localparam logic [CNT_W-1:0]  CNT_MAX   = 16'hffff;
  localparam logic [1:0]        FIELD2_RST = 2'h0;
  localparam logic [DATA_W-1:0] DATA_ZERO = 32'h0000_0000;

  typedef enum logic {FRT_BUS_IDLE, FRT_BUS_ACK} frt_bus_t;

endpackage : frt_pkg

/* File: rtl/frt_prescaler.sv */
// frt_prescaler: count-clock tick generator, divide by 1, 2, 4 or 8
`timescale 1ns/10ps
`default_nettype none
module frt_prescaler #(
  parameter int unsigned SEL_W = frt_pkg::CSEL_W,
  parameter int unsigned DIV_W = frt_pkg::DIV_W
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             run,
  input  wire logic [SEL_W-1:0] sel,
  output logic                  tick
);
  import frt_pkg::*;

  logic [DIV_W-1:0] div_r;
  logic [DIV_W-1:0] mask;

  // low sel bits of the divider must all be ones for a tick
  assign mask = ~({DIV_W{1'b1}} << sel);

  // divider free-runs only while the timer runs so start is deterministic
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      div_r <= '0;
    end else if (run) begin
      div_r <= div_r + {{(DIV_W-1){1'b0}}, 1'b1};
    end else begin
      div_r <= '0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tick <= 1'b0;
    end else begin
      tick <= run && ((div_r & mask) == mask);
    end
  end

endmodule : frt_prescaler
`default_nettype wire

/* File: rtl/frt_edge_sync.sv */
// frt_edge_sync: three-stage pin synchroniser with rise and fall pulses
`timescale 1ns/10ps
`default_nettype none
module frt_edge_sync (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic pin,
  output logic      rise,
  output logic      fall
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  logic level_r;
  logic agree;

  // a change counts only once stages two and three agree
  assign agree = (s2_r == s3_r) && (s3_r != level_r);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r    <= 1'b0;
      s2_r    <= 1'b0;
      s3_r    <= 1'b0;
      level_r <= 1'b0;
      rise    <= 1'b0;
      fall    <= 1'b0;
    end else begin
      s1_r    <= pin;
      s2_r    <= s1_r;
      s3_r    <= s2_r;
      level_r <= agree ? s3_r : level_r;
      rise    <= agree && s3_r;
      fall    <= agree && !s3_r;
    end
  end

endmodule : frt_edge_sync
`default_nettype wire

/* File: rtl/frt_timer.sv */
// frt_timer: 16-bit free-running / pulse generator timer, Avalon-MM slave
//
// What this block does
// - mode 01 counts up every count tick
// - after FFFFH set overflow, wrap, keep counting
// - overflow sticks until software writes zero
// - each register independently compare or capture
// - both compare: toggle source picks the match that toggles, either raises irq
// - compare match never disturbs the counter outside mode 11
// - A compare, B capture: A match toggles
// - B capture: trigger A edge loads, irq B
// - B captures only from trigger A
// - A captures from trigger A or B
// - only trigger B enabled: B never loads
// - both capture: toggle only if bit1 set
// - toggle source 10 is B, 11 either
// - mode 11 clears on A, pulses width B
// - pulse period is A plus one ticks
// - duty is B plus one over A plus one
// - pulse mode: A match irq A, B irq B
// - reading counter never disturbs counting
// - trigger B edge chosen by bits 6:5
`timescale 1ns/10ps
`default_nettype none
module frt_timer (
  input  wire logic                        clk,
  input  wire logic                        rst_n,
  input  wire logic [frt_pkg::ADDR_W-1:0]  avs_address,
  input  wire logic                        avs_read,
  input  wire logic                        avs_write,
  input  wire logic [frt_pkg::DATA_W-1:0]  avs_writedata,
  input  wire logic [frt_pkg::BE_W-1:0]    avs_byteenable,
  output logic      [frt_pkg::DATA_W-1:0]  avs_readdata,
  output logic                             avs_waitrequest,
  input  wire logic                        trigger_input_a,
  input  wire logic                        trigger_input_b,
  output logic                             timer_output_pin,
  output logic                             match_irq_a,
  output logic                             match_irq_b
);
  import frt_pkg::*;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  frt_bus_t           bus_state_r;
  logic [1:0]         mode_select_r;
  logic               capture_toggle_enable_r;
  logic               overflow_flag_r;
  logic               a_capture_r;
  logic               a_src_rev_r;
  logic               b_capture_r;
  logic               output_enable_bit_r;
  logic [1:0]         toggle_src_r;
  logic [CSEL_W-1:0]  clk_sel_r;
  logic [1:0]         edge_select_a_r;
  logic [1:0]         edge_select_b_r;
  logic [CNT_W-1:0]   up_counter_r;
  logic [CNT_W-1:0]   capcomp_reg_a_r;
  logic [CNT_W-1:0]   capcomp_reg_b_r;
  logic               toggle_ff_r;

  logic               tick;
  logic               rise_a;
  logic               fall_a;
  logic               rise_b;
  logic               fall_b;
  logic               run;
  logic               in_ppg;
  logic               a_is_cap;
  logic               b_is_cap;
  logic               use_rev;
  logic               match_a;
  logic               match_b;
  logic               edge_a_ok;
  logic               cap_a_ev;
  logic               cap_b_ev;
  logic               toggle_ev;
  logic               ppg_clear;
  logic               wr_en;
  logic               wr_lane0;
  logic [DATA_W-1:0]  rd_mux;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  // true when the selected edge kind is present this cycle
  function automatic logic edge_hit(input logic [1:0] sel,
                                    input logic       r,
                                    input logic       f);
    edge_hit = ((sel == EDGE_RISE) && r) || ((sel == EDGE_FALL) && f) ||
               ((sel == EDGE_BOTH) && (r || f));
  endfunction : edge_hit

  // byte-lane merge of a 16-bit register
  function automatic logic [CNT_W-1:0] be_merge(
      input logic [CNT_W-1:0]  old,
      input logic [DATA_W-1:0] wd,
      input logic [BE_W-1:0]   be);
    be_merge = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction : be_merge

  // ----------------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------------
  frt_prescaler #(
    .SEL_W (CSEL_W),
    .DIV_W (DIV_W)
  ) u_presc (
    .clk   (clk),
    .rst_n (rst_n),
    .run   (run),
    .sel   (clk_sel_r),
    .tick  (tick)
  );

  frt_edge_sync u_sync_a (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   (trigger_input_a),
    .rise  (rise_a),
    .fall  (fall_a)
  );

  frt_edge_sync u_sync_b (
    .clk   (clk),
    .rst_n (rst_n),
    .pin   (trigger_input_b),
    .rise  (rise_b),
    .fall  (fall_b)
  );

  // ----------------------------------------------------------------------
  // avalon slave: one wait cycle, then one cycle with waitrequest low
  // ----------------------------------------------------------------------
  assign wr_en    = avs_write && (bus_state_r == FRT_BUS_ACK);
  assign wr_lane0 = wr_en && avs_byteenable[0];

  // handshake state; the request is held by the master until it sees low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bus_state_r     <= FRT_BUS_IDLE;
      avs_waitrequest <= 1'b1;
    end else begin
      case (bus_state_r)
        FRT_BUS_IDLE: begin
          if (avs_read || avs_write) begin
            bus_state_r     <= FRT_BUS_ACK;
            avs_waitrequest <= 1'b0;
          end
        end
        FRT_BUS_ACK: begin
          bus_state_r     <= FRT_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          bus_state_r     <= FRT_BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // read mux; unmapped words and unused bits read zero
  always_comb begin
    rd_mux = DATA_ZERO;
    case (avs_address)
      OFS_MODE: begin
        rd_mux[MODE_SEL_LSB +: 2] = mode_select_r;
        rd_mux[MODE_CTE_BIT]      = capture_toggle_enable_r;
        rd_mux[MODE_OVF_BIT]      = overflow_flag_r;
      end
      OFS_CAPCMP: begin
        rd_mux[CC_A_CAP_BIT] = a_capture_r;
        rd_mux[CC_A_SRC_BIT] = a_src_rev_r;
        rd_mux[CC_B_CAP_BIT] = b_capture_r;
      end
      OFS_OUTCTL: begin
        rd_mux[OC_EN_BIT]       = output_enable_bit_r;
        rd_mux[OC_SRC_LSB +: 2] = toggle_src_r;
        rd_mux[OC_LVL_BIT]      = toggle_ff_r;
      end
      OFS_PRESC: begin
        rd_mux[PR_CLK_LSB +: CSEL_W] = clk_sel_r;
        rd_mux[PR_EA_LSB +: 2]       = edge_select_a_r;
        rd_mux[PR_EB_LSB +: 2]       = edge_select_b_r;
      end
      OFS_COUNT: rd_mux[CNT_W-1:0] = up_counter_r;
      OFS_REG_A: rd_mux[CNT_W-1:0] = capcomp_reg_a_r;
      OFS_REG_B: rd_mux[CNT_W-1:0] = capcomp_reg_b_r;
      default:   rd_mux = DATA_ZERO;
    endcase
  end

  // read data latched as waitrequest drops, stands through the ack cycle
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= DATA_ZERO;
    end else if ((bus_state_r == FRT_BUS_IDLE) && avs_read) begin
      avs_readdata <= rd_mux;
    end
  end

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mode_select_r           <= MODE_STOP;
      capture_toggle_enable_r <= 1'b0;
    end else if (wr_lane0 && (avs_address == OFS_MODE)) begin
      mode_select_r           <= avs_writedata[MODE_SEL_LSB +: 2];
      capture_toggle_enable_r <= avs_writedata[MODE_CTE_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      a_capture_r <= 1'b0;
      a_src_rev_r <= 1'b0;
      b_capture_r <= 1'b0;
    end else if (wr_lane0 && (avs_address == OFS_CAPCMP)) begin
      a_capture_r <= avs_writedata[CC_A_CAP_BIT];
      a_src_rev_r <= avs_writedata[CC_A_SRC_BIT];
      b_capture_r <= avs_writedata[CC_B_CAP_BIT];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      output_enable_bit_r <= 1'b0;
      toggle_src_r        <= FIELD2_RST;
    end else if (wr_lane0 && (avs_address == OFS_OUTCTL)) begin
      output_enable_bit_r <= avs_writedata[OC_EN_BIT];
      toggle_src_r        <= avs_writedata[OC_SRC_LSB +: 2];
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clk_sel_r       <= FIELD2_RST;
      edge_select_a_r <= FIELD2_RST;
      edge_select_b_r <= FIELD2_RST;
    end else if (wr_lane0 && (avs_address == OFS_PRESC)) begin
      clk_sel_r       <= avs_writedata[PR_CLK_LSB +: CSEL_W];
      edge_select_a_r <= avs_writedata[PR_EA_LSB +: 2];
      edge_select_b_r <= avs_writedata[PR_EB_LSB +: 2];
    end
  end

  // ----------------------------------------------------------------------
  // event decode
  // ----------------------------------------------------------------------
  assign run       = (mode_select_r != MODE_STOP);
  assign in_ppg    = (mode_select_r == MODE_PPG);
  // pulse mode forces both registers to compare
  assign a_is_cap  = a_capture_r && !in_ppg;
  assign b_is_cap  = b_capture_r && !in_ppg;
  // with both capturing, A must take trigger B so the two never collide
  assign use_rev   = a_src_rev_r && !b_is_cap;
  // matches are judged once per count tick, against the held count
  assign match_a   = tick && !a_is_cap && (up_counter_r == capcomp_reg_a_r);
  assign match_b   = tick && !b_is_cap && (up_counter_r == capcomp_reg_b_r);
  assign ppg_clear = in_ppg && match_a;
  assign edge_a_ok = edge_hit(edge_select_a_r, rise_a, fall_a);
  assign cap_b_ev  = b_is_cap && edge_a_ok;
  assign cap_a_ev  = a_is_cap &&
                     (use_rev ? edge_hit(edge_select_a_r, fall_a, rise_a)
                              : edge_hit(edge_select_b_r, rise_b, fall_b));

  // free-running toggles; simultaneous matches give a single inversion
  assign toggle_ev = (toggle_src_r[0] && match_a) ||
                     (toggle_src_r[1] && match_b) ||
                     (a_is_cap && b_is_cap && capture_toggle_enable_r &&
                      edge_a_ok);

  // ----------------------------------------------------------------------
  // counter and overflow
  // ----------------------------------------------------------------------
  // compare matches in free-running mode leave the count alone
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      up_counter_r <= CNT_ZERO;
    end else if (!run) begin
      up_counter_r <= CNT_ZERO;
    end else if (tick) begin
      if (ppg_clear) begin
        up_counter_r <= CNT_ZERO;
      end else begin
        up_counter_r <= up_counter_r + CNT_ONE;
      end
    end
  end

  // set wins over a software clear in the same cycle; writing 1 is ignored
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      overflow_flag_r <= 1'b0;
    end else if (tick && (up_counter_r == CNT_MAX)) begin
      overflow_flag_r <= 1'b1;
    end else if (wr_lane0 && (avs_address == OFS_MODE) &&
                 !avs_writedata[MODE_OVF_BIT]) begin
      overflow_flag_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // capture / compare registers; a capture beats a same-cycle write
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capcomp_reg_a_r <= CNT_ZERO;
    end else if (cap_a_ev) begin
      capcomp_reg_a_r <= up_counter_r;
    end else if (wr_en && (avs_address == OFS_REG_A)) begin
      capcomp_reg_a_r <= be_merge(capcomp_reg_a_r, avs_writedata,
                                  avs_byteenable);
    end
  end

  // a write mid-pulse takes effect at once; software times it safely
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      capcomp_reg_b_r <= CNT_ZERO;
    end else if (cap_b_ev) begin
      capcomp_reg_b_r <= up_counter_r;
    end else if (wr_en && (avs_address == OFS_REG_B)) begin
      capcomp_reg_b_r <= be_merge(capcomp_reg_b_r, avs_writedata,
                                  avs_byteenable);
    end
  end

  // ----------------------------------------------------------------------
  // interrupt pulses
  // ----------------------------------------------------------------------
  // reverse-phase captures of A raise no irq so pulse measuring stays quiet
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      match_irq_a <= 1'b0;
      match_irq_b <= 1'b0;
    end else begin
      match_irq_a <= match_a || (cap_a_ev && !use_rev);
      match_irq_b <= match_b || cap_b_ev;
    end
  end

  // ----------------------------------------------------------------------
  // output toggle flip-flop and pin
  // ----------------------------------------------------------------------
  // pulse mode sets at the A match (count restarts) and clears at B,
  // so the pin is high for counts 0..B: B+1 ticks out of A+1
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      toggle_ff_r <= 1'b0;
    end else if (in_ppg) begin
      if (match_a) begin
        toggle_ff_r <= 1'b1;
      end else if (match_b) begin
        toggle_ff_r <= 1'b0;
      end
    end else if (toggle_ev) begin
      toggle_ff_r <= !toggle_ff_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      timer_output_pin <= 1'b0;
    end else begin
      timer_output_pin <= output_enable_bit_r && toggle_ff_r;
    end
  end

endmodule : frt_timer
`default_nettype wire

/* File: test/frt_checker.sv */
// frt_checker: port assertions for the timer
`timescale 1ns/10ps
`default_nettype none
module frt_checker (
  input wire logic                       clk,
  input wire logic                       rst_n,
  input wire logic [frt_pkg::ADDR_W-1:0] avs_address,
  input wire logic                       avs_read,
  input wire logic                       avs_write,
  input wire logic [frt_pkg::DATA_W-1:0] avs_writedata,
  input wire logic                       avs_waitrequest,
  input wire logic                       timer_output_pin,
  input wire logic                       match_irq_a,
  input wire logic                       match_irq_b
);
  import frt_pkg::*;
  logic       en_r;
  logic       cte_r;
  logic [2:0] enh_r;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // shadow of enables from acked writes; the pin lags a write
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      en_r  <= 1'b0;
      cte_r <= 1'b0;
      enh_r <= 3'h0;
    end else begin
      if (avs_write && !avs_waitrequest && avs_address == OFS_OUTCTL)
        en_r <= avs_writedata[OC_EN_BIT];
      if (avs_write && !avs_waitrequest && avs_address == OFS_MODE)
        cte_r <= avs_writedata[MODE_CTE_BIT];
      enh_r <= {enh_r[1:0], en_r};
    end
  end
  chk_wait_short:
    assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low too long");
  chk_req_answered:
    assert property ((avs_read || avs_write) && avs_waitrequest
                     |=> !avs_waitrequest)
    else $error("request not answered");
  chk_ack_has_req:
    assert property ($fell(avs_waitrequest)
                     |-> $past(avs_read) || $past(avs_write))
    else $error("ack without request");
  chk_idle_no_ack:
    assert property (!avs_read && !avs_write |=> avs_waitrequest)
    else $error("ack while idle");
  chk_irq_a_pulse:
    assert property (match_irq_a |=> !match_irq_a)
    else $error("irq a longer than a cycle");
  chk_irq_b_pulse:
    assert property (match_irq_b |=> !match_irq_b)
    else $error("irq b longer than a cycle");
  chk_pin_disabled:
    assert property (!en_r && !enh_r[0] |-> !timer_output_pin)
    else $error("pin active while disabled");
  chk_toggle_cause:
    assert property ($changed(timer_output_pin) && (&enh_r) && !cte_r
                     |-> $past(match_irq_a) || $past(match_irq_b))
    else $error("pin moved without a match");
  cover property (match_irq_a);
  cover property (match_irq_b);
  cover property ($rose(timer_output_pin));
endmodule : frt_checker
`default_nettype wire

/* File: test/frt_pins.sv */
// frt_pins: external pulse sources on the two trigger pins
`timescale 1ns/10ps
`default_nettype none
module frt_pins (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       fire_a,
  input  wire logic       fire_b,
  input  wire logic [7:0] len,
  output var  logic       trig_a,
  output var  logic       trig_b
);
  logic [7:0] cnt_a_r;
  logic [7:0] cnt_b_r;
  // a request starts a high pulse of len clocks, short or slow;
  // the sources idle low, so only the rising edge is a fresh event
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_a_r <= 8'h00;
      cnt_b_r <= 8'h00;
    end else begin
      cnt_a_r <= fire_a ? len : cnt_a_r - {7'h0, cnt_a_r != 8'h00};
      cnt_b_r <= fire_b ? len : cnt_b_r - {7'h0, cnt_b_r != 8'h00};
    end
  end
  assign trig_a = cnt_a_r != 8'h00;
  assign trig_b = cnt_b_r != 8'h00;
endmodule : frt_pins
`default_nettype wire

/* File: test/frt_timer_tb.sv */
// frt_timer_tb: self-checking bench of the timer
`timescale 1ns/10ps
`default_nettype none
module frt_timer_tb;
  import frt_pkg::*;
  logic              clk;
  logic              rst_n;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read;
  logic              avs_write;
  logic [DATA_W-1:0] avs_writedata;
  logic [DATA_W-1:0] avs_readdata;
  logic              avs_waitrequest;
  logic              trig_a;
  logic              trig_b;
  logic              pin;
  logic              irq_a;
  logic              irq_b;
  logic              fire_a;
  logic              fire_b;
  logic [7:0]        len;
  logic [DATA_W-1:0] q;
  logic [DATA_W-1:0] c0;
  logic              hit;
  logic              p;
  int                cyc;
  int                error_cnt;
  int                n_tests;
  frt_timer u_dut (.clk, .rst_n, .avs_address, .avs_read, .avs_write,
    .avs_writedata, .avs_byteenable(4'hf), .avs_readdata,
    .avs_waitrequest, .trigger_input_a(trig_a), .trigger_input_b(trig_b),
    .timer_output_pin(pin), .match_irq_a(irq_a), .match_irq_b(irq_b));
  frt_pins u_pins (.clk, .rst_n, .fire_a, .fire_b, .len, .trig_a, .trig_b);
  // 100 MHz clock
  always #5 clk = ~clk;
  task automatic report_and_stop;
    $display("checks %0d errors %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic ok, input string m);
    n_tests++;
    if (ok !== 1'b1) begin
      error_cnt++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask : chk
  // one bus cycle; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [2:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 40);
    chk(n < 40, "bus hang");
    if (n >= 40) report_and_stop();
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : bus
  // s: 0 irq a, 1 irq b, 2 pin high, 3 pin low; cyc counts edges
  task automatic wait_on(input int s, input int lim);
    hit = 1'b0;
    for (cyc = 0; cyc < lim && hit !== 1'b1; cyc++) begin
      @(posedge clk);
      hit = (s == 0) ? irq_a : (s == 1) ? irq_b : pin ^ (s == 3);
    end
  endtask : wait_on
  task automatic pulse(input logic b, input logic [7:0] w);
    @(posedge clk);
    len    <= w;
    fire_a <= !b;
    fire_b <= b;
    @(posedge clk);
    fire_a <= 1'b0;
    fire_b <= 1'b0;
  endtask : pulse
  task automatic t_reset;
    bus(0, OFS_MODE, 0);
    chk(q === DATA_ZERO, "mode not reset");
    bus(0, OFS_COUNT, 0);
    chk(q === DATA_ZERO, "count moves while stopped");
    bus(1, 3'h7, 32'hffff_ffff);
    bus(0, 3'h7, 0);
    chk(q === DATA_ZERO, "unmapped read");
    $display("t_reset done");
  endtask : t_reset
  task automatic t_ppg;
    bus(1, OFS_OUTCTL, 32'h01);
    bus(1, OFS_PRESC, 32'h02);
    bus(1, OFS_REG_A, 32'h9);
    bus(1, OFS_REG_B, 32'h3);
    bus(1, OFS_MODE, 32'h0c);
    wait_on(0, 200);
    chk(hit, "no irq a");
    wait_on(1, 100);
    chk(hit, "no irq b");
    wait_on(2, 100);
    wait_on(3, 100);
    c0 = cyc;
    wait_on(2, 100);
    chk(c0 === 16, "pulse width");
    chk(c0 + cyc === 40, "pulse period");
    bus(1, OFS_OUTCTL, 32'h00);
    repeat (3) @(posedge clk);
    chk(pin === 1'b0, "pin not off");
    $display("t_ppg done");
  endtask : t_ppg
  task automatic t_free;
    bus(1, OFS_MODE, 32'h00);
    bus(1, OFS_PRESC, 32'h00);
    bus(1, OFS_REG_A, 32'h40);
    bus(1, OFS_REG_B, 32'h80);
    bus(1, OFS_OUTCTL, 32'h0d);
    bus(1, OFS_MODE, 32'h04);
    p = pin;
    wait_on(0, 200);
    repeat (2) @(posedge clk);
    chk(hit && pin === !p, "a match toggle");
    wait_on(1, 200);
    repeat (2) @(posedge clk);
    chk(hit && pin === p, "b match toggle");
    bus(0, OFS_COUNT, 0);
    c0 = q;
    bus(0, OFS_COUNT, 0);
    chk(q - c0 === 32'h3, "count rate");
    chk(c0 > 32'h80, "count disturbed");
    for (int n = 0; n < 30000 && q[0] !== 1'b1; n++)
      bus(0, OFS_MODE, 0);
    bus(0, OFS_COUNT, 0);
    chk(q < 32'h20, "no wrap");
    bus(0, OFS_MODE, 0);
    chk(q[0] === 1'b1, "overflow lost");
    bus(1, OFS_MODE, 32'h04);
    bus(0, OFS_MODE, 0);
    chk(q[0] === 1'b0, "overflow stuck");
    $display("t_free done");
  endtask : t_free
  task automatic t_cap;
    bus(1, OFS_OUTCTL, 32'h01);
    bus(1, OFS_CAPCMP, 32'h05);
    bus(1, OFS_PRESC, 32'h28);
    bus(0, OFS_COUNT, 0);
    c0 = q;
    pulse(1, 8'd4);
    wait_on(0, 30);
    chk(hit, "no capture irq a");
    bus(0, OFS_REG_A, 0);
    chk(q > c0 && q < c0 + 32'd40, "a capture value");
    bus(0, OFS_REG_B, 0);
    chk(q === 32'h80, "b loaded by trigger b");
    p = pin;
    bus(0, OFS_COUNT, 0);
    c0 = q;
    pulse(0, 8'd12);
    wait_on(1, 30);
    chk(hit, "no capture irq b");
    bus(0, OFS_REG_B, 0);
    chk(q > c0 && q < c0 + 32'd40, "b capture value");
    chk(pin === p, "pin moved on capture");
    c0 = q;
    bus(1, OFS_PRESC, 32'h30);
    pulse(0, 8'd4);
    wait_on(1, 30);
    chk(!hit, "b irq with trigger a off");
    bus(0, OFS_REG_B, 0);
    chk(q === c0, "b loaded with trigger a off");
    bus(1, OFS_PRESC, 32'h28);
    bus(1, OFS_MODE, 32'h06);
    pulse(0, 8'd4);
    wait_on(1, 30);
    repeat (4) @(posedge clk);
    chk(pin === !p, "capture toggle");
    $display("t_cap done");
  endtask : t_cap
  // reset for five cycles, then the scenarios in turn
  initial begin
    clk           = 1'b0;
    rst_n         = 1'b0;
    avs_address   = '0;
    avs_read      = 1'b0;
    avs_write     = 1'b0;
    avs_writedata = '0;
    fire_a        = 1'b0;
    fire_b        = 1'b0;
    len           = 8'h04;
    error_cnt     = 0;
    n_tests       = 0;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_reset();
    t_ppg();
    t_free();
    t_cap();
    report_and_stop();
  end
endmodule : frt_timer_tb
bind frt_timer frt_checker u_chk (.clk, .rst_n, .avs_address, .avs_read,
  .avs_write, .avs_writedata, .avs_waitrequest, .timer_output_pin,
  .match_irq_a, .match_irq_b);
`default_nettype wire
